/* core/usart_tx_pkg.sv */
// constants shared by the serial transmit control block
package usart_tx_pkg;
  // register byte addresses
  localparam logic [7:0] TXCS_OFFSET  = 8'h98; // transmit_control_status
  localparam logic [7:0] RXCS_OFFSET  = 8'h9C; // receive_control_status
  localparam logic [7:0] TXDATA_OFFSET = 8'hA0; // transmit data
  localparam logic [7:0] DIR_OFFSET   = 8'hA4; // port_c_direction_bits
  localparam logic [7:0] BAUD_OFFSET  = 8'hA8; // baud divisor
  localparam logic [7:0] IRQ_STAT_OFFSET = 8'hAC; // sticky events
  localparam logic [7:0] IRQ_MASK_OFFSET = 8'hB0; // event mask
  // transmit_control_status fields
  localparam int CLKSRC_BIT   = 7;
  localparam int NINE_SEL_BIT = 6;
  localparam int XMIT_EN_BIT  = 5;
  localparam int SYNC_BIT = 4;
  localparam int HBAUD_BIT = 2;
  localparam int EMPTY_BIT = 1;
  localparam int NINTH_BIT = 0;
  // receive_control_status fields
  localparam int PORT_EN_BIT   = 7;
  localparam int SINGLE_RX_BIT = 5;
  localparam int CONT_RX_BIT   = 4;
  // writable mask of transmit_control_status
  localparam logic [7:0] TXCS_WMASK = 8'hF5;
  localparam logic [7:0] TXCS_RESET = 8'h02;
  localparam logic [7:0] RXCS_RESET = 8'h00;
  localparam logic [1:0] DIR_RESET  = 2'h3;
  localparam logic [15:0] BAUD_RESET = 16'h0019;
  // interrupt event bits
  localparam int EV_TX_DONE = 0;
  localparam int EV_ADDR    = 1;
  localparam int EV_W       = 2;
  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // shift engine states
  typedef enum logic [1:0]
  {
    ST_IDLE  = 2'b00,
    ST_SHIFT = 2'b01,
    ST_STOP  = 2'b10
  } tx_state_t;
endpackage

/* core/usart_transmit_control.sv */
// transmit control, status and shift engine of a serial port
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/10ps
// Function
// - pins serve port only when enabled and directed
// - async full, sync master, sync slave modes
// - sync: clock source select chooses master/slave
// - nine-bit select picks 9 or 8 bits
// - transmitter enable gates transmission
// - mode select chooses sync or async
// - async high baud select picks speed range
// - empty flag reads one when shifter idle
// - ninth bit marks address characters
module usart_transmit_control
  import usart_tx_pkg::*;
(
  input  wire logic        aclk,          // system clock
  input  wire logic        aresetn,       // sync reset, active low
  input  wire logic [7:0]  s_axi_awaddr,  // write address
  input  wire logic        s_axi_awvalid, // write address valid
  output logic             s_axi_awready, // write address ready
  input  wire logic [31:0] s_axi_wdata,   // write data
  input  wire logic [3:0]  s_axi_wstrb,   // write strobes
  input  wire logic        s_axi_wvalid,  // write data valid
  output logic             s_axi_wready,  // write data ready
  output logic [1:0]       s_axi_bresp,   // write response
  output logic             s_axi_bvalid,  // write response valid
  input  wire logic        s_axi_bready,  // write response ready
  input  wire logic [7:0]  s_axi_araddr,  // read address
  input  wire logic        s_axi_arvalid, // read address valid
  output logic             s_axi_arready, // read address ready
  output logic [31:0]      s_axi_rdata,   // read data
  output logic [1:0]       s_axi_rresp,   // read response
  output logic             s_axi_rvalid,  // read data valid
  input  wire logic        s_axi_rready,  // read data ready
  input  wire logic        ck_in,         // clock pin level
  output logic             ck_out,        // clock pin drive value
  output logic             ck_oe,         // clock pin drive enable
  output logic             tx_out,        // data pin drive value
  output logic             tx_oe,         // data pin drive enable
  output logic             irq            // level interrupt
);

  ////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0]  txcs_reg;
  logic [7:0]  rxcs_reg;
  logic [1:0]  dir_reg;
  logic [15:0] baud_reg;
  logic [8:0]  txbuf_reg;
  logic        txbuf_full_reg;
  logic [2:0]  istat_reg;
  logic [2:0]  imask_reg;
  logic        aw_held_reg;
  logic        w_held_reg;
  logic [7:0]  awaddr_reg;
  logic [31:0] wdata_reg;
  logic        wstrb0_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;
  tx_state_t   state_reg;
  logic [9:0]  shift_reg;
  logic [3:0]  bits_left_reg;
  logic [17:0] bcnt_reg;
  logic        ck_gen_reg;
  logic        ck_s1_reg;
  logic        ck_s2_reg;
  logic        ck_s3_reg;
  logic        done_pulse_reg;
  logic        addr_pulse_reg;
  logic        txo_reg;

  ////////////////////////////////////////////////////////////////////////
  // mode decode
  wire pins_on   = rxcs_reg[PORT_EN_BIT] & (&dir_reg);
  wire sync_mode = txcs_reg[SYNC_BIT];
  wire master    = sync_mode & txcs_reg[CLKSRC_BIT];
  wire rx_prio   = sync_mode &
                   (rxcs_reg[SINGLE_RX_BIT] | rxcs_reg[CONT_RX_BIT]);
  wire tx_on     = txcs_reg[XMIT_EN_BIT] & ~rx_prio & pins_on;
  wire nine      = txcs_reg[NINE_SEL_BIT];
  wire tx_busy   = (state_reg != ST_IDLE);

  // async high range divides by 16, low range by 64; sync by 4
  wire [17:0] div_full = sync_mode ? {baud_reg, 2'b00} :
                         txcs_reg[HBAUD_BIT] ? {baud_reg[13:0], 4'h0} :
                         {baud_reg[11:0], 6'h00};
  wire [17:0] div_half = {1'b0, div_full[17:1]};

  // bit tick: internal divider or slave clock falling edge
  wire ck_fall  = ck_s3_reg & ~ck_s2_reg;
  wire int_tick = (bcnt_reg >= div_full - 18'h1);
  wire ck_edge  = (bcnt_reg == div_half - 18'h1);
  wire bit_tick = (sync_mode & ~master) ? ck_fall : int_tick;

  ////////////////////////////////////////////////////////////////////////
  // bus decode
  wire do_write = aw_held_reg & w_held_reg & ~bvalid_reg;
  wire do_read  = s_axi_arvalid & ~rvalid_reg;
  wire [7:0] wb = wdata_reg[7:0];
  wire wr_txcs  = do_write & wstrb0_reg & (awaddr_reg == TXCS_OFFSET);
  wire wr_rxcs  = do_write & wstrb0_reg & (awaddr_reg == RXCS_OFFSET);
  wire wr_data  = do_write & wstrb0_reg & (awaddr_reg == TXDATA_OFFSET);
  wire wr_dir   = do_write & wstrb0_reg & (awaddr_reg == DIR_OFFSET);
  wire wr_baud  = do_write & (awaddr_reg == BAUD_OFFSET);
  wire wr_istat = do_write & wstrb0_reg & (awaddr_reg == IRQ_STAT_OFFSET);
  wire wr_imask = do_write & wstrb0_reg & (awaddr_reg == IRQ_MASK_OFFSET);
  wire w_hit    = (awaddr_reg == TXCS_OFFSET) | (awaddr_reg == RXCS_OFFSET)
                | (awaddr_reg == TXDATA_OFFSET) | (awaddr_reg == DIR_OFFSET)
                | (awaddr_reg == BAUD_OFFSET)
                | (awaddr_reg == IRQ_STAT_OFFSET)
                | (awaddr_reg == IRQ_MASK_OFFSET);
  // status byte with live empty flag, bit 3 reads zero
  wire [7:0] txcs_rd = {txcs_reg[7:4], 1'b0, txcs_reg[HBAUD_BIT],
                        ~tx_busy, txcs_reg[NINTH_BIT]};
  wire [31:0] rd_mux =
    (s_axi_araddr == TXCS_OFFSET)     ? {24'h0, txcs_rd} :
    (s_axi_araddr == RXCS_OFFSET)     ? {24'h0, rxcs_reg} :
    (s_axi_araddr == TXDATA_OFFSET)   ? {23'h0, txbuf_reg} :
    (s_axi_araddr == DIR_OFFSET)      ? {30'h0, dir_reg} :
    (s_axi_araddr == BAUD_OFFSET)     ? {16'h0, baud_reg} :
    (s_axi_araddr == IRQ_STAT_OFFSET) ? {29'h0, istat_reg} :
    (s_axi_araddr == IRQ_MASK_OFFSET) ? {29'h0, imask_reg} : 32'h0;
  wire r_hit = (s_axi_araddr == TXCS_OFFSET) | (s_axi_araddr == RXCS_OFFSET)
             | (s_axi_araddr == TXDATA_OFFSET) | (s_axi_araddr == DIR_OFFSET)
             | (s_axi_araddr == BAUD_OFFSET)
             | (s_axi_araddr == IRQ_STAT_OFFSET)
             | (s_axi_araddr == IRQ_MASK_OFFSET);

  // bus handshake outputs
  assign s_axi_awready = ~aw_held_reg;
  assign s_axi_wready  = ~w_held_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  ////////////////////////////////////////////////////////////////////////
  // write channel capture and response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      awaddr_reg  <= 8'h00;
      wdata_reg   <= 32'h0;
      wstrb0_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid & ~aw_held_reg)
      begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (s_axi_wvalid & ~w_held_reg)
      begin
        w_held_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb0_reg <= s_axi_wstrb[0];
      end
      if (do_write)
      begin
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= w_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid_reg & s_axi_bready)
        bvalid_reg <= 1'b0;
    end
  end

  // read channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0;
      rresp_reg  <= RESP_OKAY;
    end
    else if (do_read)
    begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_mux;
      rresp_reg  <= r_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rvalid_reg & s_axi_rready)
      rvalid_reg <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // control registers; empty flag and bit 3 keep their fixed sources
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      txcs_reg  <= TXCS_RESET;
      rxcs_reg  <= RXCS_RESET;
      dir_reg   <= DIR_RESET;
      baud_reg  <= BAUD_RESET;
      imask_reg <= 3'h0;
    end
    else
    begin
      if (wr_txcs)
        txcs_reg <= (wb & TXCS_WMASK) | TXCS_RESET;
      if (wr_rxcs)
        rxcs_reg <= wb;
      if (wr_dir)
        dir_reg <= wb[1:0];
      if (wr_baud)
        baud_reg <= wdata_reg[15:0];
      if (wr_imask)
        imask_reg <= wb[2:0];
    end
  end

  // transmit holding buffer; ninth bit latched with the data
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      txbuf_reg      <= 9'h000;
      txbuf_full_reg <= 1'b0;
    end
    else if (wr_data & ~txbuf_full_reg)
    begin
      txbuf_reg      <= {txcs_reg[NINTH_BIT], wb};
      txbuf_full_reg <= 1'b1;
    end
    else if (state_reg == ST_IDLE & tx_on & txbuf_full_reg)
      txbuf_full_reg <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // clock pin synchroniser, third stage for edge detect
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ck_s1_reg <= 1'b1;
      ck_s2_reg <= 1'b1;
      ck_s3_reg <= 1'b1;
    end
    else
    begin
      ck_s1_reg <= ck_in;
      ck_s2_reg <= ck_s1_reg;
      ck_s3_reg <= ck_s2_reg;
    end
  end

  // shift engine: async adds start and stop, sync shifts lsb first
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg      <= ST_IDLE;
      shift_reg      <= 10'h3FF;
      bits_left_reg  <= 4'h0;
      bcnt_reg       <= 18'h0;
      ck_gen_reg     <= 1'b1;
      txo_reg        <= 1'b1;
      done_pulse_reg <= 1'b0;
      addr_pulse_reg <= 1'b0;
    end
    else
    begin
      done_pulse_reg <= 1'b0;
      addr_pulse_reg <= 1'b0;
      bcnt_reg <= (tx_busy & ~int_tick) ? bcnt_reg + 18'h1 : 18'h0;
      case (state_reg)
        ST_IDLE:
        begin
          txo_reg    <= 1'b1;
          ck_gen_reg <= 1'b1;
          if (tx_on & txbuf_full_reg)
          begin
            state_reg <= ST_SHIFT;
            // ninth bit flags an address character
            addr_pulse_reg <= nine & txbuf_reg[8];
            if (sync_mode)
            begin
              shift_reg     <= {1'b1, nine ? txbuf_reg[8] : 1'b1,
                                txbuf_reg[7:0]};
              bits_left_reg <= nine ? 4'h9 : 4'h8;
            end
            else
            begin
              shift_reg     <= nine ? {txbuf_reg, 1'b0} :
                                      {1'b1, txbuf_reg[7:0], 1'b0};
              bits_left_reg <= nine ? 4'hA : 4'h9;
            end
          end
        end
        ST_SHIFT:
        begin
          txo_reg <= shift_reg[0];
          if (master & ck_edge)
            ck_gen_reg <= 1'b1;
          if (bit_tick)
          begin
            ck_gen_reg    <= 1'b0;
            shift_reg     <= {1'b1, shift_reg[9:1]};
            bits_left_reg <= bits_left_reg - 4'h1;
            if (bits_left_reg == 4'h1)
              state_reg <= ST_STOP;
          end
        end
        ST_STOP:
        begin
          txo_reg    <= 1'b1;
          ck_gen_reg <= 1'b1;
          if (bit_tick | (sync_mode & master & ck_edge))
          begin
            state_reg      <= ST_IDLE;
            done_pulse_reg <= 1'b1;
          end
        end
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sticky events, set wins over write-one clear
  wire [2:0] ev_set = {wr_data & txbuf_full_reg, addr_pulse_reg,
                       done_pulse_reg};
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      istat_reg <= 3'h0;
    else
      istat_reg <= (istat_reg & ~(wr_istat ? wb[2:0] : 3'h0)) | ev_set;
  end

  // pin drivers
  always_comb
  begin
    tx_out = txo_reg;
    tx_oe  = pins_on & (~sync_mode | tx_busy);
    ck_out = master ? ck_gen_reg : 1'b1;
    ck_oe  = pins_on & master;
    irq    = |(istat_reg & imask_reg);
  end

endmodule

/* tb/usart_tx_chk.sv */
// port assertions for the serial transmit control block
`timescale 1ns/10ps
module usart_tx_chk
  import usart_tx_pkg::*;
(
  input wire logic        aclk,          // clock
  input wire logic        aresetn,       // reset
  input wire logic        s_axi_awready, // aw ready
  input wire logic        s_axi_wready,  // w ready
  input wire logic        s_axi_arvalid, // ar valid
  input wire logic        s_axi_arready, // ar ready
  input wire logic [1:0]  s_axi_bresp,   // b resp
  input wire logic        s_axi_bvalid,  // b valid
  input wire logic        s_axi_bready,  // b ready
  input wire logic [31:0] s_axi_rdata,   // r data
  input wire logic [1:0]  s_axi_rresp,   // r resp
  input wire logic        s_axi_rvalid,  // r valid
  input wire logic        s_axi_rready,  // r ready
  input wire logic        ck_oe,         // clock enable
  input wire logic        tx_out,        // data value
  input wire logic        tx_oe,         // data enable
  input wire logic        irq            // interrupt
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////
  // a taken read address and the answer that follows
  sequence s_rd_req;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_rd_ans;
    s_axi_rvalid;
  endsequence
  property p_rd_ans;
    s_rd_req |=> s_rd_ans;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("no read answer");
  // answers stand until taken
  property p_b_stand;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_stand: assert property (p_b_stand) else $error("bvalid lost");
  property p_r_stand;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_stand: assert property (p_r_stand) else $error("rvalid lost");
  // read data shape
  property p_r_upper;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
  endproperty
  a_r_upper: assert property (p_r_upper) else $error("upper bits set");
  property p_r_err;
    s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0;
  endproperty
  a_r_err: assert property (p_r_err) else $error("error with data");
  // state right after reset
  property p_rst_pins;
    $rose(aresetn) |-> !tx_oe && !ck_oe && tx_out && !irq;
  endproperty
  a_rst_pins: assert property (p_rst_pins) else $error("pins driven");
  property p_rst_bus;
    $rose(aresetn) |-> s_axi_awready && s_axi_wready && s_axi_arready
      && !s_axi_bvalid && !s_axi_rvalid;
  endproperty
  a_rst_bus: assert property (p_rst_bus) else $error("bus not idle");
  // the interrupt only drops through a register write
  property p_irq_fall;
    $fell(irq) && $past(aresetn) |-> s_axi_bvalid;
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell");
endmodule
bind usart_transmit_control usart_tx_chk usart_tx_chk_i (.aclk(aclk),
  .aresetn(aresetn), .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .ck_oe(ck_oe), .tx_out(tx_out), .tx_oe(tx_oe), .irq(irq));

/* tb/usart_tx_partner.sv */
// far-side serial peer: async frame receiver and slave clock source
`timescale 1ns/10ps
module usart_tx_partner
(
  input  wire logic       aclk,     // sampling clock
  input  wire logic       line,     // data wire level
  input  wire logic       async_en, // listen for frames
  input  wire logic       nine,     // nine data bits
  input  wire logic       slave_go, // start a burst
  input  wire logic [7:0] bit_clks, // clocks per bit
  output logic            ck_in,    // link clock
  output logic [9:0]      rx_data,  // stop and data bits
  output logic            rx_stb    // frame strobe
);
  logic [9:0] d;
  initial
  begin
    ck_in = 1'h1;
    rx_stb = 1'h0;
    rx_data = 10'h0;
  end
  // sample each bit in its middle, lsb first, stop bit last
  always
  begin
    @(negedge line iff async_en);
    d = 10'h0;
    repeat (bit_clks / 2) @(negedge aclk);
    for (int i = 0; i <= (nine ? 9 : 8); i++)
    begin
      repeat (bit_clks) @(negedge aclk);
      d[i] = line;
    end
    rx_data <= d;
    rx_stb <= 1'h1;
    @(negedge aclk);
    rx_stb <= 1'h0;
  end
  // clock burst of 80 ns cycles, standing high between bursts
  always @(posedge slave_go)
  begin
    #13;
    repeat (12)
    begin
      ck_in = 1'h0;
      #40;
      ck_in = 1'h1;
      #40;
    end
  end
endmodule

/* tb/usart_transmit_control_tb_top.sv */
// self-checking bench of the serial transmit control block
`timescale 1ns/10ps
`define CHK(g, w) begin n_tests++; if ((g) !== (w)) begin fails++; \
  $display("unexpected at %0t: got %h want %h", $time, g, w); end end
module usart_transmit_control_tb_top
  import usart_tx_pkg::*;
;
  logic        aclk = 1'h0;
  logic        aresetn = 1'h0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic        arvalid = 1'h0, rready = 1'h0;
  logic        async_en = 1'h1, nine = 1'h0, slave_go = 1'h0;
  logic [7:0]  bit_clks = 8'h40;
  logic [31:0] seed = 32'h5D1A;
  logic [33:0] exp_r;
  logic [9:0]  exp_f;
  logic        hi, ninth;
  logic [7:0]  cs;
  logic [33:0] rq[$];
  logic [9:0]  fq[$];
  int          fails = 0, n_tests = 0;
  wire logic   awready, wready, bvalid, arready, rvalid, ck_out, ck_oe;
  wire logic   tx_out, tx_oe, irq, ck_in, rx_stb, line;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [9:0]  rx_data;
  // data wire has a pull-up when the block lets go
  assign line = tx_oe ? tx_out : 1'h1;
  always #5 aclk = ~aclk;
  ////////////////////////////////////////////////////////////////////////
  usart_transmit_control usart_transmit_control_i (.aclk(aclk),
    .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .ck_in(ck_in), .ck_out(ck_out), .ck_oe(ck_oe),
    .tx_out(tx_out), .tx_oe(tx_oe), .irq(irq));
  usart_tx_partner usart_tx_partner_i (.aclk(aclk), .line(line),
    .async_en(async_en), .nine(nine), .slave_go(slave_go),
    .bit_clks(bit_clks), .ck_in(ck_in), .rx_data(rx_data),
    .rx_stb(rx_stb));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // bus write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw;
    ta = 1'h0;
    tw = 1'h0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!(ta && tw))
    begin
      @(negedge aclk);
      ta = ta | (awvalid & awready);
      tw = tw | (wvalid & wready);
      @(posedge aclk);
      if (ta) awvalid <= 1'h0;
      if (tw) wvalid <= 1'h0;
    end
    do @(negedge aclk); while (bvalid !== 1'h1);
    @(posedge aclk);
    bready <= 1'h0;
  endtask
  // bus read: the expected answer is noted before the request
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    rq.push_back(e);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(negedge aclk); while (arready !== 1'h1);
    @(posedge aclk);
    arvalid <= 1'h0;
    do @(negedge aclk); while (rvalid !== 1'h1);
    @(posedge aclk);
    rready <= 1'h0;
  endtask
  task automatic settle();
    repeat (4) @(negedge aclk);
  endtask
  task automatic wait_irq();
    do @(negedge aclk); while (irq !== 1'h1);
    @(posedge aclk);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // take the oldest note whenever a read answer or a frame appears
  always @(negedge aclk)
  begin
    if (rvalid && rready)
    begin
      exp_r = rq.pop_front();
      `CHK({rresp, rdata}, exp_r)
    end
    if (rx_stb)
    begin
      exp_f = fq.pop_front();
      `CHK(rx_data, exp_f)
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    rd(TXCS_OFFSET, {RESP_OKAY, 32'h02});
    rd(8'hFC, {RESP_SLVERR, 32'h0});
    wr(TXCS_OFFSET, 32'hFF);
    rd(TXCS_OFFSET, {RESP_OKAY, 32'hF7});
    wr(BAUD_OFFSET, 32'h1);
    wr(IRQ_MASK_OFFSET, 32'h1);
    wr(TXCS_OFFSET, 32'h20);
    $display("test registers done");
    wr(DIR_OFFSET, 32'h0);
    wr(RXCS_OFFSET, 32'h80);
    settle();
    `CHK(tx_oe, 1'h0)
    wr(DIR_OFFSET, 32'h3);
    settle();
    `CHK(tx_oe, 1'h1)
    $display("test pins done");
    for (int m = 0; m < 3; m++)
    begin
      hi = (m > 0);
      ninth = (m == 2);
      nine <= hi;
      bit_clks <= hi ? 8'h10 : 8'h40;
      seed = lfsr(seed);
      cs = {1'h0, hi, 1'h1, 2'h0, hi, 1'h0, ninth};
      fq.push_back(hi ? {1'h1, ninth, seed[7:0]} : {2'h1, seed[7:0]});
      wr(TXCS_OFFSET, {24'h0, cs});
      wr(TXDATA_OFFSET, {24'h0, seed[7:0]});
      settle();
      rd(TXCS_OFFSET, {RESP_OKAY, 24'h0, cs});
      wait_irq();
      rd(IRQ_STAT_OFFSET, {RESP_OKAY, 30'h0, ninth, 1'h1});
      wr(IRQ_STAT_OFFSET, 32'h3);
      settle();
      `CHK(irq, 1'h0)
    end
    $display("test async frames done");
    async_en <= 1'h0;
    nine <= 1'h0;
    wr(RXCS_OFFSET, 32'h90);
    wr(TXCS_OFFSET, 32'hB0);
    wr(TXDATA_OFFSET, 32'hA5);
    wr(TXDATA_OFFSET, 32'h5A);
    repeat (200) @(posedge aclk);
    rd(IRQ_STAT_OFFSET, {RESP_OKAY, 32'h4});
    wr(RXCS_OFFSET, 32'h80);
    settle();
    `CHK(ck_oe, 1'h1)
    wait_irq();
    `CHK(ck_out, 1'h1)
    `CHK(tx_oe, 1'h0)
    wr(IRQ_STAT_OFFSET, 32'h5);
    wr(TXCS_OFFSET, 32'h30);
    settle();
    `CHK(ck_oe, 1'h0)
    wr(TXDATA_OFFSET, 32'h3C);
    slave_go <= 1'h1;
    wait_irq();
    slave_go <= 1'h0;
    rd(IRQ_STAT_OFFSET, {RESP_OKAY, 32'h1});
    settle();
    $display("test sync frames done");
    tally_and_finish();
  end
  // watchdog against a hang
  initial
  begin
    repeat (60000) @(posedge aclk);
    fails++;
    tally_and_finish();
  end
endmodule
